/* File: rtl/rrs_defs.vh */
// Constants of the remote reset supervisor: offsets, fields, resets, timing.
// Assumes a 125 MHz hclk and a single AHB-Lite master.
`ifndef RRS_DEFS_VH
`define RRS_DEFS_VH
`define RRS_CLK_HZ 64'd125000000
`define RRS_SANITY_S 64'd24
`define RRS_WARN_MS 64'd750
`define RRS_HOLD_US 64'd2900
`define RRS_HOLD_CLKS 32
`define RRS_DISP_US 64'd1000
`define RRS_SANITY_CYC (`RRS_SANITY_S * `RRS_CLK_HZ)
`define RRS_WARN_CYC (`RRS_WARN_MS * `RRS_CLK_HZ / 64'd1000)
`define RRS_HOLD_CYC (`RRS_HOLD_US * `RRS_CLK_HZ / 64'd1000000)
`define RRS_DISP_CYC (`RRS_DISP_US * `RRS_CLK_HZ / 64'd1000000)
`define RRS_A_CTRL 6'h00
`define RRS_A_STAT 6'h04
`define RRS_A_CMD 6'h08
`define RRS_A_SAN 6'h0C
`define RRS_A_BOARD 6'h10
`define RRS_A_CLR 6'h14
`define RRS_CTRL_RST 0
`define RRS_CTRL_JAM 1
`define RRS_CTRL_SDIS 2
`define RRS_CTRL_NMI 3
`define RRS_CTRL_CHB 4
`define RRS_CTRL_TRN 6
`define RRS_CTRL_SCAN 7
`define RRS_CTRL_SLAVE 8
`define RRS_CTRL_CORE 9
`define RRS_CTRL_W 10
`define RRS_CTRL_INIT 10'h000
`define RRS_BOARD_INIT 8'h00
`define RRS_CHB_232 2'h0
`define RRS_CHB_422 2'h1
`define RRS_CHB_LOOP 2'h2
`define RRS_LINK_RST 8'h52
`define RRS_NSRC 5
`define RRS_SRC_NONE 3'h7
`define RRS_ID_EQ 32'h0000_1111
`define RRS_ID_HW 32'h0000_0001
`define RRS_ID_BASE 32'h0000_0001
`define RRS_ID_FW 32'h0000_0001
`endif

/* File: rtl/rrs_top.v */
// Reset supervisor core: sanity timer, command arbiter, processor control,
// jam exchange, channel steering, identification store, indicators, display.
// Assumes all inputs synchronous to hclk and character strobes one cycle wide.
`include "rrs_defs.vh"

// Contract
// - Sanity expiry resets microcontroller after 24 s
// - Early warning 0.75 s before; service restarts
// - Expiry reset held 2.9 ms, 362500 clocks
// - Power fail holds whole card in reset
// - Link resets act only in slave subsystem
// - Attached terminal on core shelf blocks link resets
// - Drive reset, jam, sanity disable, top interrupt
// - Exchange jam state, refuse double jam
// - Channel B: RS-232, RS-422 or loopback
// - Port 3 wired to maintenance channel A
// - Transparent relay hides originating terminal
// - Exactly two receive-only sideband links
// - Sideband resets blocked by a master; code still queued
// - Responses to link commands go to terminals; code sends them only in transparent mode
// - Remote port: terminal or alarm scanner mode
// - Identification word 32 bit, even parity
// - Store equipment code and three releases
// - Green for sync, red for inactive
// - Continuously refresh status and board display
// - Local terminal has highest priority
module rrs_top #(
	parameter [63:0] SANITY_CYC = `RRS_SANITY_CYC,
	parameter [63:0] WARN_CYC = `RRS_WARN_CYC,
	parameter [63:0] HOLD_CYC = `RRS_HOLD_CYC,
	parameter [63:0] DISP_CYC = `RRS_DISP_CYC
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	input wire power_good,
	input wire local_char_valid,
	input wire [7:0] local_char,
	input wire cpu_char_valid,
	input wire [7:0] cpu_char,
	input wire remote_char_valid,
	input wire [7:0] remote_char,
	input wire link0_valid,
	input wire [7:0] link0_code,
	input wire link1_valid,
	input wire [7:0] link1_code,
	input wire local_attached,
	input wire remote_attached,
	input wire mate_jam,
	input wire cpu_sync,
	input wire cpu_active,
	input wire cpu_in_service,
	input wire clk_status,
	input wire clk_active,
	input wire p3_txd,
	input wire maint_a_txd,
	input wire id_rd,
	input wire [1:0] id_addr,
	output reg [31:0] id_data,
	output reg id_parity,
	output wire card_reset,
	output wire mcu_reset,
	output wire mcu_warn,
	output wire cpu_reset,
	output wire cpu_jam,
	output wire cpu_sanity_dis,
	output wire cpu_nmi,
	output wire jam_state,
	output wire chb_rs232,
	output wire chb_rs422,
	output wire chb_loop,
	output wire remote_scanner,
	output reg p3_rxd,
	output reg maint_a_rxd,
	output reg maint_valid,
	output reg [7:0] maint_data,
	output reg term_resp_valid,
	output reg [7:0] term_resp_data,
	output wire led_green,
	output wire led_red,
	output reg [2:0] disp_sel,
	output reg [7:0] disp_data
);

	function [2:0] pick;
		input [4:0] v;
		integer k;
		begin
			pick = `RRS_SRC_NONE;
			for (k = `RRS_NSRC - 1; k >= 0; k = k - 1) begin
				if (v[k]) begin
					pick = k[2:0];
				end
			end
		end
	endfunction

	function [31:0] id_word;
		input [1:0] a;
		begin
			case (a)
				2'd0: id_word = `RRS_ID_EQ;
				2'd1: id_word = `RRS_ID_HW;
				2'd2: id_word = `RRS_ID_BASE;
				default: id_word = `RRS_ID_FW;
			endcase
		end
	endfunction

	reg [`RRS_CTRL_W-1:0] ctrl;
	reg [7:0] board;
	reg [31:0] san_cnt;
	reg warn;
	reg [31:0] hold_cnt;
	reg jam_act;
	reg jam_refused;
	reg link_rst;
	reg [4:0] pend;
	reg [7:0] pdat [0:4];
	reg ph_act;
	reg ph_wr;
	reg [5:0] ph_addr;
	reg [31:0] disp_cnt;
	reg [2:0] src_sel;
	wire [4:0] in_v;
	wire [39:0] in_d;
	wire [2:0] top;
	wire cmd_rd;
	wire pop;
	wire wr_ctrl;
	wire wr_san;
	wire wr_board;
	wire wr_clr;
	wire master;
	wire char_seen;
	wire link_hit;
	wire jam_req;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_act <= 1'b0;
			ph_wr <= 1'b0;
			ph_addr <= 6'h00;
		end else if (hready) begin
			ph_act <= hsel & htrans[1];
			ph_wr <= hwrite;
			ph_addr <= haddr[5:0];
		end
	end

	assign wr_ctrl = ph_act & ph_wr & (ph_addr == `RRS_A_CTRL);
	assign wr_san = ph_act & ph_wr & (ph_addr == `RRS_A_SAN);
	assign wr_board = ph_act & ph_wr & (ph_addr == `RRS_A_BOARD);
	assign wr_clr = ph_act & ph_wr & (ph_addr == `RRS_A_CLR);
	assign cmd_rd = ph_act & ~ph_wr & (ph_addr == `RRS_A_CMD);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `RRS_CTRL_INIT;
			board <= `RRS_BOARD_INIT;
		end else if (!power_good) begin
			ctrl <= `RRS_CTRL_INIT;
			board <= `RRS_BOARD_INIT;
		end else begin
			if (wr_ctrl) begin
				ctrl <= hwdata[`RRS_CTRL_W-1:0];
			end
			if (wr_board) begin
				board <= hwdata[7:0];
			end
		end
	end

	// Read data is driven in the data phase; unmapped offsets read zero
	always @* begin
		hrdata = 32'h0000_0000;
		if (ph_act & ~ph_wr) begin
			case (ph_addr)
				`RRS_A_CTRL: hrdata = {22'h00_0000, ctrl};
				`RRS_A_STAT: hrdata = {17'h0_0000, pend, 4'h0, mate_jam,
					~power_good, master, jam_refused, jam_act, warn};
				`RRS_A_CMD: hrdata = (top == `RRS_SRC_NONE) ? 32'h0000_0000 :
					{20'h0_0000, 1'b1, top, pdat[top]};
				`RRS_A_BOARD: hrdata = {24'h00_0000, board};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Sanity timer; terminal and processor characters and SAN writes keep it alive
	assign char_seen = local_char_valid | cpu_char_valid | remote_char_valid;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			san_cnt <= 32'h0000_0000;
			warn <= 1'b0;
			hold_cnt <= 32'h0000_0000;
		end else if (!power_good) begin
			san_cnt <= 32'h0000_0000;
			warn <= 1'b0;
			hold_cnt <= 32'h0000_0000;
		end else begin
			if (char_seen | wr_san | (hold_cnt != 32'h0000_0000)) begin
				san_cnt <= 32'h0000_0000;
			end else if (san_cnt == SANITY_CYC[31:0] - 32'h0000_0001) begin
				san_cnt <= 32'h0000_0000;
				hold_cnt <= HOLD_CYC[31:0];
			end else begin
				san_cnt <= san_cnt + 32'h0000_0001;
			end
			if (hold_cnt != 32'h0000_0000) begin
				hold_cnt <= hold_cnt - 32'h0000_0001;
			end
			// Warning stays up until serviced or the timer fires anyway
			if (san_cnt == SANITY_CYC[31:0] - WARN_CYC[31:0] - 32'h0000_0001
				&& !(char_seen | wr_san)) begin
				warn <= 1'b1;
			end else if (wr_san | char_seen | (hold_cnt != 32'h0000_0000)) begin
				warn <= 1'b0;
			end
		end
	end
	assign mcu_warn = warn;
	assign mcu_reset = (hold_cnt != 32'h0000_0000) | ~power_good;
	assign card_reset = ~power_good;

	// Five sources; each holds one pending character until taken
	assign in_v = {link1_valid, link0_valid, remote_char_valid, cpu_char_valid,
		local_char_valid};
	assign in_d = {link1_code, link0_code, remote_char, cpu_char, local_char};
	assign top = pick(pend);
	assign pop = cmd_rd | (ctrl[`RRS_CTRL_TRN] & (top != `RRS_SRC_NONE));

	genvar g;
	generate
		for (g = 0; g < `RRS_NSRC; g = g + 1) begin : g_src
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pend[g] <= 1'b0;
					pdat[g] <= 8'h00;
				end else if (in_v[g]) begin
					pend[g] <= 1'b1;
					pdat[g] <= in_d[g*8 +: 8];
				end else if (pop && top == g) begin
					pend[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Transparent relay: one character a cycle, source identity dropped
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			maint_valid <= 1'b0;
			maint_data <= 8'h00;
			term_resp_valid <= 1'b0;
			term_resp_data <= 8'h00;
			src_sel <= `RRS_SRC_NONE;
		end else begin
			maint_valid <= 1'b0;
			term_resp_valid <= 1'b0;
			if (ctrl[`RRS_CTRL_TRN] && top != `RRS_SRC_NONE && top != 3'd1) begin
				maint_valid <= 1'b1;
				maint_data <= pdat[top];
				src_sel <= top;
			end
			// Links have no return path, so in transparent mode answers go to terminals
			if (ctrl[`RRS_CTRL_TRN] && cpu_char_valid) begin
				term_resp_valid <= 1'b1;
				term_resp_data <= cpu_char;
			end
		end
	end

	// Direct link reset, gated by subsystem role and master presence
	assign master = ctrl[`RRS_CTRL_CORE] & (local_attached | remote_attached);
	assign link_hit = (link0_valid & (link0_code == `RRS_LINK_RST)) |
		(link1_valid & (link1_code == `RRS_LINK_RST));
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_rst <= 1'b0;
		end else begin
			link_rst <= link_hit & ctrl[`RRS_CTRL_SLAVE] & ~master;
		end
	end

	// Jam exchange with the mate card
	assign jam_req = ctrl[`RRS_CTRL_JAM];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			jam_act <= 1'b0;
			jam_refused <= 1'b0;
		end else begin
			if (!jam_req) begin
				jam_act <= 1'b0;
			end else if (!mate_jam) begin
				jam_act <= 1'b1;
			end
			if (jam_req & mate_jam & ~jam_act) begin
				jam_refused <= 1'b1;
			end else if (wr_clr & hwdata[0]) begin
				jam_refused <= 1'b0;
			end
		end
	end
	assign jam_state = jam_act;

	assign cpu_reset = ctrl[`RRS_CTRL_RST] | link_rst | ~power_good;
	assign cpu_jam = jam_act;
	assign cpu_sanity_dis = ctrl[`RRS_CTRL_SDIS];
	assign cpu_nmi = ctrl[`RRS_CTRL_NMI];

	// Code 3 leaves channel B unconnected
	assign chb_rs232 = ctrl[`RRS_CTRL_CHB +: 2] == `RRS_CHB_232;
	assign chb_rs422 = ctrl[`RRS_CTRL_CHB +: 2] == `RRS_CHB_422;
	assign chb_loop = ctrl[`RRS_CTRL_CHB +: 2] == `RRS_CHB_LOOP;
	assign remote_scanner = ctrl[`RRS_CTRL_SCAN];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p3_rxd <= 1'b1;
			maint_a_rxd <= 1'b1;
		end else begin
			p3_rxd <= maint_a_txd;
			maint_a_rxd <= p3_txd;
		end
	end

	// Identification store; parity bit makes the 33 bits even
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			id_data <= 32'h0000_0000;
			id_parity <= 1'b0;
		end else if (id_rd) begin
			id_data <= id_word(id_addr);
			id_parity <= ^id_word(id_addr);
		end
	end

	assign led_green = cpu_sync;
	assign led_red = ~cpu_active | ~cpu_in_service;

	// Display scan, one field per divider tick
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			disp_cnt <= 32'h0000_0000;
			disp_sel <= 3'd0;
			disp_data <= 8'h00;
		end else begin
			if (disp_cnt == DISP_CYC[31:0] - 32'h0000_0001) begin
				disp_cnt <= 32'h0000_0000;
				disp_sel <= (disp_sel == 3'd4) ? 3'd0 : disp_sel + 3'd1;
			end else begin
				disp_cnt <= disp_cnt + 32'h0000_0001;
			end
			case (disp_sel)
				3'd0: disp_data <= {7'h00, cpu_active};
				3'd1: disp_data <= {7'h00, cpu_sync};
				3'd2: disp_data <= {7'h00, clk_status};
				3'd3: disp_data <= {7'h00, clk_active};
				default: disp_data <= board;
			endcase
		end
	end

endmodule // rrs_top

/* File: tb/rrs_assertions.sv */
// Checker for the reset supervisor core, bound to its ports.
// Assumes one hclk domain and the short sim counts of the bench.
module rrs_assertions (
	input logic hclk,
	input logic hresetn,
	input logic power_good,
	input logic card_reset,
	input logic mcu_reset,
	input logic mcu_warn,
	input logic cpu_reset,
	input logic cpu_jam,
	input logic jam_state,
	input logic mate_jam,
	input logic chb_rs232,
	input logic chb_rs422,
	input logic chb_loop,
	input logic p3_rxd,
	input logic maint_a_txd,
	input logic maint_a_rxd,
	input logic p3_txd,
	input logic id_rd,
	input logic [31:0] id_data,
	input logic id_parity,
	input logic [2:0] disp_sel,
	input logic led_green,
	input logic led_red,
	input logic cpu_sync,
	input logic cpu_active,
	input logic cpu_in_service
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Expiry, not a power dip, starts the hold
	sequence s_exp;
		$rose(mcu_reset) && power_good && $past(power_good);
	endsequence
	pwr_hold_a: assert property (!power_good |-> card_reset && mcu_reset && cpu_reset)
		else $error("power fail reset missing");
	warn_lead_a: assert property (s_exp |-> $past(mcu_warn))
		else $error("expiry without warning");
	hold_len_a: assert property (s_exp |-> mcu_reset [*8])
		else $error("expiry reset too short");
	jam_mirror_a: assert property (cpu_jam == jam_state)
		else $error("jam line and jam state differ");
	jam_refuse_a: assert property ($rose(jam_state) |-> !$past(mate_jam))
		else $error("jam taken while mate jammed");
	chb_one_a: assert property ($onehot0({chb_loop, chb_rs422, chb_rs232}))
		else $error("channel b two paths");
	port3_a: assert property ($past(hresetn) |-> p3_rxd == $past(maint_a_txd)
		&& maint_a_rxd == $past(p3_txd))
		else $error("port 3 relay broken");
	id_par_a: assert property (id_rd |=> ^{id_data, id_parity} == 1'b0)
		else $error("identification parity odd");
	disp_step_a: assert property ($changed(disp_sel) && $past(hresetn) && power_good
		|-> disp_sel == ($past(disp_sel) == 3'h4 ? 3'h0 : $past(disp_sel) + 3'h1))
		else $error("display field skipped");
	led_a: assert property (led_green == cpu_sync
		&& led_red == (!cpu_active || !cpu_in_service))
		else $error("indicator wrong");
endmodule // rrs_assertions

/* File: tb/rrs_cpu_model.sv */
// Model of the processor card: status levels, maintenance line, characters.
// Assumes it shares hclk with the supervisor core.
module rrs_cpu_model (
	input logic hclk,
	input logic p3_rxd,
	output logic cpu_char_valid = 0,
	output logic [7:0] cpu_char = 0,
	output logic cpu_sync,
	output logic cpu_active,
	output logic cpu_in_service,
	output logic clk_status,
	output logic clk_active,
	output logic maint_a_txd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] ph = 0;
	// Slow walk so every indicator combination shows up
	always @(posedge hclk) ph <= ph + 6'h01;
	assign {cpu_sync, cpu_active, cpu_in_service, clk_status, clk_active} = ph[5:1];
	assign maint_a_txd = ph[0] ^ ph[2];
	task send(input logic [7:0] c);
		cpu_char <= c;
		cpu_char_valid <= 1;
		@(posedge hclk);
		cpu_char_valid <= 0;
	endtask
endmodule // rrs_cpu_model

/* File: tb/tb_remote_reset_supervisor.sv */
// Self-checking bench for the supervisor core over AHB-Lite.
// Assumes sim counts: sanity 200, warn 20, hold 10, display 4.
`include "rrs_defs.vh"
module tb_remote_reset_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, power_good = 1, p3_txd = 1;
	logic [31:0] haddr = 0, hwdata = 0, rq, r;
	logic [1:0] htrans = 0, id_addr = 0;
	logic [2:0] hsize = 3'h2;
	logic local_char_valid = 0, remote_char_valid = 0, link0_valid = 0, link1_valid = 0;
	logic [7:0] local_char = 0, remote_char = 0, link0_code = 0, link1_code = 0;
	logic local_attached = 0, remote_attached = 0, mate_jam = 0, id_rd = 0;
	logic cpu_char_valid, cpu_sync, cpu_active, cpu_in_service, clk_status, clk_active;
	logic maint_a_txd;
	logic [7:0] cpu_char, got_m, got_t;
	wire hreadyout, hresp, id_parity, card_reset, mcu_reset, mcu_warn, cpu_reset, cpu_jam;
	wire cpu_sanity_dis, cpu_nmi, jam_state, chb_rs232, chb_rs422, chb_loop, remote_scanner;
	wire p3_rxd, maint_a_rxd, maint_valid, term_resp_valid, led_green, led_red;
	wire [31:0] hrdata, id_data;
	wire [7:0] maint_data, term_resp_data, disp_data;
	wire [2:0] disp_sel;
	int n_errors = 0, num_checks = 0, n_cr = 0, c0, k;
	logic [31:0] idw [4] = '{`RRS_ID_EQ, `RRS_ID_HW, `RRS_ID_BASE, `RRS_ID_FW};
	rrs_top #(.SANITY_CYC(200), .WARN_CYC(20), .HOLD_CYC(10), .DISP_CYC(4))
		i_rrs_top (.hready(hreadyout), .*);
	rrs_cpu_model i_rrs_cpu_model (.*);
	initial forever #4 hclk = ~hclk;
	always @(posedge hclk) begin
		rq <= hrdata;
		p3_txd <= ~p3_txd;
		if (cpu_reset === 1'b1) n_cr <= n_cr + 1;
		if (maint_valid === 1'b1) got_m <= maint_data;
		if (term_resp_valid === 1'b1) got_t <= term_resp_data;
	end
	task chk(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Data phase value is taken from the edge capture to avoid a read race
	task bus(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		#1 r = rq;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task t_regs;
		bus(0, 0, 0); chk("ctrl reset", r, 0);
		bus(1, 0, 32'h0000_008D); bus(0, 0, 0); chk("ctrl", r, 32'h0000_008D);
		chk("cpu lines", {remote_scanner, cpu_nmi, cpu_sanity_dis, cpu_reset}, 4'hF);
		for (int i = 0; i < 3; i++) begin
			bus(1, 0, i << 4);
			chk("chan b", {chb_loop, chb_rs422, chb_rs232}, 1 << i);
		end
		bus(0, 32'h0000_003C, 0); chk("unmapped", r, 0);
		bus(1, 0, 0);
		$display("regs done");
	endtask
	task t_arb;
		@(posedge hclk);
		{local_char_valid, remote_char_valid, link0_valid, link1_valid} <= 4'hF;
		local_char <= 8'h10; remote_char <= 8'h12; link0_code <= 8'h13; link1_code <= 8'h14;
		i_rrs_cpu_model.send(8'h11);
		{local_char_valid, remote_char_valid, link0_valid, link1_valid} <= 4'h0;
		for (int s = 0; s < 5; s++) begin
			bus(0, 32'h0000_0008, 0);
			chk("command", r, 32'h800 | s << 8 | 32'h10 + s);
		end
		bus(0, 32'h0000_0008, 0); chk("queue empty", r[11], 0);
		$display("arbitration done");
	endtask
	task t_link;
		bus(1, 0, 32'h0000_0100);
		c0 = n_cr;
		@(posedge hclk) link0_valid <= 1; link0_code <= 8'h52;
		@(posedge hclk) link0_valid <= 0;
		cyc(3); chk("slave reset", n_cr - c0, 1);
		bus(1, 0, 32'h0000_0300);
		@(posedge hclk) local_attached <= 1;
		cyc(2); c0 = n_cr;
		@(posedge hclk) link1_valid <= 1; link1_code <= 8'h52;
		@(posedge hclk) link1_valid <= 0;
		cyc(3); chk("master blocks", n_cr - c0, 0);
		bus(0, 32'h0000_0008, 0); chk("link0 kept", r, 32'h0000_0B52);
		bus(0, 32'h0000_0008, 0); chk("link1 kept", r, 32'h0000_0C52);
		@(posedge hclk) local_attached <= 0; remote_attached <= 1;
		cyc(2); c0 = n_cr;
		@(posedge hclk) link0_valid <= 1; link0_code <= 8'h52;
		@(posedge hclk) link0_valid <= 0;
		cyc(3); chk("remote master", n_cr - c0, 0);
		bus(0, 32'h0000_0008, 0); chk("link0 again", r, 32'h0000_0B52);
		@(posedge hclk) remote_attached <= 0;
		bus(1, 0, 0);
		$display("links done");
	endtask
	task t_jam;
		bus(1, 0, 2); cyc(2); chk("jam", cpu_jam, 1);
		bus(1, 0, 0);
		@(posedge hclk) mate_jam <= 1;
		bus(1, 0, 2); cyc(2); chk("jam refused", cpu_jam, 0);
		bus(0, 4, 0); chk("refused flag", r[2], 1);
		bus(1, 0, 0); bus(1, 32'h0000_0014, 1);
		bus(0, 4, 0); chk("flag cleared", r[2], 0);
		@(posedge hclk) mate_jam <= 0;
		$display("jam done");
	endtask
	task t_sanity;
		bus(1, 32'h0000_000C, 0);
		k = 0;
		while (mcu_warn !== 1'b1 && k < 400) begin cyc(1); k++; end
		k = 0;
		while (mcu_reset !== 1'b1 && k < 400) begin cyc(1); k++; end
		chk("warn lead", k, 20);
		k = 0;
		while (mcu_reset === 1'b1 && k < 400) begin cyc(1); k++; end
		chk("hold", k, 10);
		bus(1, 32'h0000_000C, 0); cyc(120);
		@(posedge hclk) remote_char_valid <= 1; remote_char <= 8'h20;
		@(posedge hclk) remote_char_valid <= 0;
		k = 0;
		repeat (150) begin cyc(1); k += (mcu_warn === 1'b1); end
		chk("char restart", k, 0);
		$display("sanity done");
	endtask
	task t_relay;
		bus(1, 0, 32'h0000_0040); cyc(2);
		@(posedge hclk) local_char_valid <= 1; local_char <= 8'hA5;
		@(posedge hclk) local_char_valid <= 0;
		i_rrs_cpu_model.send(8'h3C);
		cyc(3); chk("relay", got_m, 8'hA5);
		chk("response", got_t, 8'h3C);
		bus(1, 0, 0);
		$display("relay done");
	endtask
	task t_id;
		for (int a = 0; a < 4; a++) begin
			@(posedge hclk) id_rd <= 1; id_addr <= a[1:0];
			@(posedge hclk) id_rd <= 0;
			#1 chk("id word", id_data, idw[a]);
			chk("id parity", id_parity, ^idw[a]);
		end
		$display("id done");
	endtask
	task t_pwr;
		bus(1, 32'h0000_0010, 32'h0000_005A); bus(1, 0, 32'h0000_0080);
		k = 0;
		while (disp_sel !== 3'd4 && k < 20) begin cyc(1); k++; end
		cyc(1); chk("display board", disp_data, 8'h5A);
		@(posedge hclk) power_good <= 0;
		cyc(2); chk("pf resets", {card_reset, mcu_reset, cpu_reset}, 3'h7);
		@(posedge hclk) power_good <= 1;
		bus(0, 0, 0); chk("pf ctrl", r, 0);
		bus(0, 32'h0000_0010, 0); chk("pf board", r, 0);
		$display("power done");
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		t_regs; t_arb; t_link; t_jam; t_sanity; t_relay; t_id; t_pwr;
		test_done;
	end
	// Whole run is under a thousand cycles; this is far beyond it
	initial begin
		#100000;
		n_errors++;
		test_done;
	end
endmodule // tb_remote_reset_supervisor
bind rrs_top rrs_assertions i_rrs_assertions (.*);
